// ==== rtl/cpu_status_core_control_map.svh ====
// register offsets, field positions and the control reset value of the status/control bank
// assumes inclusion by bare name from the design file and the bench
`ifndef CPU_STATUS_CORE_CONTROL_MAP_SVH
`define CPU_STATUS_CORE_CONTROL_MAP_SVH
`define STATUS_OFS 12'h000
`define CONTROL_OFS 12'h004
`define SIDE_OFS 12'h008
`define ST_ACCA_OVF 15
`define ST_ACCB_OVF 14
`define ST_ACCA_STICKY 13
`define ST_ACCB_STICKY 12
`define ST_EITHER_OVF 11
`define ST_EITHER_STICKY 10
`define ST_DO_ACTIVE 9
`define ST_HALF_CARRY 8
`define ST_PRIO_HI 7
`define ST_PRIO_LO 5
`define ST_REPEAT 4
`define ST_NEG 3
`define ST_WRAP 2
`define ST_ZERO 1
`define ST_CARRY 0
`define CC_UNSIGNED 12
`define CC_EARLY_EXIT 11
`define CC_DEPTH_HI 10
`define CC_DEPTH_LO 8
`define CC_CLIP_A 7
`define CC_CLIP_B 6
`define CC_CLIP_DW 5
`define CC_CLIP_WIDTH 4
`define CC_PRIO_MSB 3
`define CC_PROG_WIN 2
`define SD_NEST_DIS 0
`define CONTROL_RESET 16'h0020
`endif

// ==== rtl/cpu_status_core_control_pkg.sv ====
// types for the status/control bank
// does not include the map header; depends on no other file
package cpu_status_core_control_pkg;
  typedef struct packed {
    logic valid;
    logic byte_op;
    logic [15:0] result;
    logic carry_msb;
    logic carry_low;
    logic wrap;
    logic upd_zero;
  } alu_flags_t;
  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic sat_a;
    logic sat_b;
  } acc_events_t;
  typedef struct packed {
    logic unsigned_mul;
    logic clip_a;
    logic clip_b;
    logic clip_dw;
    logic clip_wide;
    logic prog_win;
    logic early_exit;
    logic [3:0] priority_level;
    logic user_irq_block;
  } dsp_cfg_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;
endpackage

// ==== rtl/cpu_status_core_control.sv ====
// status word and core control word, APB slave, one clock
// assumes datapath inputs come from logic on clk; nothing is asynchronous
`timescale 1ns/10ps
`include "cpu_status_core_control_map.svh"

module cpu_status_core_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cpu_status_core_control_pkg::alu_flags_t alu_flags,
  input wire cpu_status_core_control_pkg::acc_events_t acc_events,
  input wire logic do_loop_active,
  input wire logic repeat_loop_busy,
  input wire logic [2:0] do_nest_depth,
  input wire logic do_early_exit_taken,
  output cpu_status_core_control_pkg::dsp_cfg_t dsp_cfg
);

  typedef struct packed {
    cpu_status_core_control_pkg::bus_state_t bus;
    logic [31:0] rdata;
    logic slverr;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_sticky_clip;
    logic acc_b_sticky_clip;
    logic half_carry_flag;
    logic [2:0] cpu_priority_level;
    logic neg_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic carry_flag;
    logic [15:0] core_control_reg;
    logic nesting_disable;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `STATUS_OFS) || (a == `CONTROL_OFS) || (a == `SIDE_OFS);
  endfunction

  logic [15:0] cpu_status_reg;
  logic [15:0] control_view;
  logic access;
  logic commit;
  logic wr_lo;
  logic wr_hi;

  always_comb begin
    cpu_status_reg = 16'h0000;
    cpu_status_reg[`ST_ACCA_OVF] = s_r.acc_a_overflow;
    cpu_status_reg[`ST_ACCB_OVF] = s_r.acc_b_overflow;
    cpu_status_reg[`ST_ACCA_STICKY] = s_r.acc_a_sticky_clip;
    cpu_status_reg[`ST_ACCB_STICKY] = s_r.acc_b_sticky_clip;
    cpu_status_reg[`ST_EITHER_OVF] = s_r.acc_a_overflow | s_r.acc_b_overflow;
    cpu_status_reg[`ST_EITHER_STICKY] = s_r.acc_a_sticky_clip | s_r.acc_b_sticky_clip;
    cpu_status_reg[`ST_DO_ACTIVE] = do_loop_active;
    cpu_status_reg[`ST_HALF_CARRY] = s_r.half_carry_flag;
    cpu_status_reg[`ST_PRIO_HI:`ST_PRIO_LO] = s_r.cpu_priority_level;
    cpu_status_reg[`ST_REPEAT] = repeat_loop_busy;
    cpu_status_reg[`ST_NEG] = s_r.neg_flag;
    cpu_status_reg[`ST_WRAP] = s_r.signed_wrap_flag;
    cpu_status_reg[`ST_ZERO] = s_r.zero_flag;
    cpu_status_reg[`ST_CARRY] = s_r.carry_flag;
    control_view = s_r.core_control_reg;
    control_view[`CC_EARLY_EXIT] = 1'b0;
    control_view[`CC_DEPTH_HI:`CC_DEPTH_LO] = do_nest_depth;
  end

  always_comb begin
    s_nxt = s_r;
    access = psel && penable && (s_r.bus == cpu_status_core_control_pkg::BUS_IDLE);
    // writes land on the pready edge, so a master that drops the
    // request early never half-commits a value
    commit = psel && penable && pwrite && (s_r.bus == cpu_status_core_control_pkg::BUS_DONE);
    wr_lo = commit && pstrb[0];
    wr_hi = commit && pstrb[1];
    s_nxt.bus = access ? cpu_status_core_control_pkg::BUS_DONE : cpu_status_core_control_pkg::BUS_IDLE;
    if (access) begin
      s_nxt.slverr = !known_addr(paddr);
      s_nxt.rdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `STATUS_OFS: s_nxt.rdata = {16'h0000, cpu_status_reg};
          `CONTROL_OFS: s_nxt.rdata = {16'h0000, control_view};
          `SIDE_OFS: s_nxt.rdata = {31'h0000_0000, s_r.nesting_disable};
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (paddr == `STATUS_OFS) begin
      if (wr_hi) begin
        // sticky bits: written zero clears, written one ignored
        if (!pwdata[`ST_ACCA_STICKY]) s_nxt.acc_a_sticky_clip = 1'b0;
        if (!pwdata[`ST_ACCB_STICKY]) s_nxt.acc_b_sticky_clip = 1'b0;
        if (!pwdata[`ST_EITHER_STICKY]) begin
          s_nxt.acc_a_sticky_clip = 1'b0;
          s_nxt.acc_b_sticky_clip = 1'b0;
        end
        s_nxt.half_carry_flag = pwdata[`ST_HALF_CARRY];
      end
      if (wr_lo) begin
        if (!s_r.nesting_disable) s_nxt.cpu_priority_level = pwdata[`ST_PRIO_HI:`ST_PRIO_LO];
        s_nxt.neg_flag = pwdata[`ST_NEG];
        s_nxt.signed_wrap_flag = pwdata[`ST_WRAP];
        s_nxt.zero_flag = pwdata[`ST_ZERO];
        s_nxt.carry_flag = pwdata[`ST_CARRY];
      end
    end
    if (paddr == `CONTROL_OFS) begin
      if (wr_hi) begin
        s_nxt.core_control_reg[`CC_UNSIGNED] = pwdata[`CC_UNSIGNED];
        if (pwdata[`CC_EARLY_EXIT]) s_nxt.core_control_reg[`CC_EARLY_EXIT] = 1'b1;
      end
      if (wr_lo) begin
        s_nxt.core_control_reg[`CC_CLIP_A] = pwdata[`CC_CLIP_A];
        s_nxt.core_control_reg[`CC_CLIP_B] = pwdata[`CC_CLIP_B];
        s_nxt.core_control_reg[`CC_CLIP_DW] = pwdata[`CC_CLIP_DW];
        s_nxt.core_control_reg[`CC_CLIP_WIDTH] = pwdata[`CC_CLIP_WIDTH];
        // priority msb can only be cleared by software
        if (!pwdata[`CC_PRIO_MSB]) s_nxt.core_control_reg[`CC_PRIO_MSB] = 1'b0;
        s_nxt.core_control_reg[`CC_PROG_WIN] = pwdata[`CC_PROG_WIN];
      end
    end
    if ((paddr == `SIDE_OFS) && wr_lo) s_nxt.nesting_disable = pwdata[`SD_NEST_DIS];
    // exit request holds until the loop controller takes it or do_loop_active drops
    if (do_early_exit_taken || !do_loop_active) s_nxt.core_control_reg[`CC_EARLY_EXIT] = 1'b0;
    // datapath events last so a set beats a same-cycle clear
    s_nxt.acc_a_overflow = acc_events.ovf_a;
    s_nxt.acc_b_overflow = acc_events.ovf_b;
    if (acc_events.sat_a) s_nxt.acc_a_sticky_clip = 1'b1;
    if (acc_events.sat_b) s_nxt.acc_b_sticky_clip = 1'b1;
    if (alu_flags.valid) begin
      s_nxt.neg_flag = alu_flags.byte_op ? alu_flags.result[7] : alu_flags.result[15];
      s_nxt.signed_wrap_flag = alu_flags.wrap;
      s_nxt.carry_flag = alu_flags.carry_msb;
      s_nxt.half_carry_flag = alu_flags.carry_low;
      if (alu_flags.upd_zero) begin
        if (alu_flags.byte_op ? (alu_flags.result[7:0] != 8'h00) : (alu_flags.result != 16'h0000)) begin
          s_nxt.zero_flag = 1'b0;
        end else begin
          s_nxt.zero_flag = 1'b1;
        end
      end
    end
    s_nxt.core_control_reg[15:13] = 3'h0;
    s_nxt.core_control_reg[`CC_DEPTH_HI:`CC_DEPTH_LO] = 3'h0;
    s_nxt.core_control_reg[1:0] = 2'h0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.bus <= cpu_status_core_control_pkg::BUS_IDLE;
      s_r.core_control_reg <= `CONTROL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready = (s_r.bus == cpu_status_core_control_pkg::BUS_DONE);
  assign pslverr = pready && s_r.slverr;
  assign prdata = s_r.rdata;

  always_comb begin
    dsp_cfg.unsigned_mul = s_r.core_control_reg[`CC_UNSIGNED];
    dsp_cfg.clip_a = s_r.core_control_reg[`CC_CLIP_A];
    dsp_cfg.clip_b = s_r.core_control_reg[`CC_CLIP_B];
    dsp_cfg.clip_dw = s_r.core_control_reg[`CC_CLIP_DW];
    dsp_cfg.clip_wide = s_r.core_control_reg[`CC_CLIP_WIDTH];
    dsp_cfg.prog_win = s_r.core_control_reg[`CC_PROG_WIN];
    dsp_cfg.early_exit = s_r.core_control_reg[`CC_EARLY_EXIT];
    dsp_cfg.priority_level = {s_r.core_control_reg[`CC_PRIO_MSB], s_r.cpu_priority_level};
    dsp_cfg.user_irq_block = s_r.core_control_reg[`CC_PRIO_MSB] || (s_r.cpu_priority_level == 3'h7);
  end

  sticky_hold_a: assert property (@(posedge clk) disable iff (reset)
    acc_events.sat_a |=> s_r.acc_a_sticky_clip)
    else $error("sticky clip A not set after saturation");
  sticky_noset_a: assert property (@(posedge clk) disable iff (reset)
    (!acc_events.sat_a && !s_r.acc_a_sticky_clip) |=> !s_r.acc_a_sticky_clip)
    else $error("sticky clip A set without saturation");
  combined_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr_hi && paddr == `STATUS_OFS && !pwdata[`ST_EITHER_STICKY] && !acc_events.sat_a && !acc_events.sat_b)
    |=> !cpu_status_reg[`ST_EITHER_STICKY])
    else $error("combined sticky clear did not clear both");
  prio_lock_a: assert property (@(posedge clk) disable iff (reset)
    s_r.nesting_disable |=> $stable(s_r.cpu_priority_level) || !$past(s_r.nesting_disable))
    else $error("priority changed while nesting disabled");
  irq_block_a: assert property (@(posedge clk) disable iff (reset)
    dsp_cfg.priority_level[3] |-> dsp_cfg.user_irq_block)
    else $error("user interrupts not blocked at high priority");
  zero_sticky_a: assert property (@(posedge clk) disable iff (reset)
    (s_r.zero_flag && !(alu_flags.valid && alu_flags.upd_zero) && !(wr_lo && paddr == `STATUS_OFS))
    |=> s_r.zero_flag)
    else $error("zero flag dropped without a result");
  carry_track_a: assert property (@(posedge clk) disable iff (reset)
    alu_flags.valid |=> s_r.carry_flag == $past(alu_flags.carry_msb))
    else $error("carry flag wrong");
  wrap_track_a: assert property (@(posedge clk) disable iff (reset)
    alu_flags.valid |=> s_r.signed_wrap_flag == $past(alu_flags.wrap))
    else $error("wrap flag wrong");
  apb_answer_a: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");
  reset_dw_a: assert property (@(posedge clk) $past(reset) |-> s_r.core_control_reg == `CONTROL_RESET)
    else $error("control reset value wrong");
  cover_sat: cover property (@(posedge clk) disable iff (reset) acc_events.sat_a ##1 wr_hi);
  cover_block: cover property (@(posedge clk) disable iff (reset) dsp_cfg.user_irq_block);
  cover_exit: cover property (@(posedge clk) disable iff (reset) dsp_cfg.early_exit ##1 do_early_exit_taken);
  cover_lock: cover property (@(posedge clk) disable iff (reset) s_r.nesting_disable && wr_lo);
  cover_zero: cover property (@(posedge clk) disable iff (reset) s_r.zero_flag && alu_flags.valid);

  // bus side: one wait state, single-cycle answer
  pready_pulse_a: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("pready held over two cycles");
  slverr_flag_a: assert property (@(posedge clk) disable iff (reset)
    (access && !known_addr(paddr)) |=> pslverr)
    else $error("unmapped access not flagged");
  rdata_hold_a: assert property (@(posedge clk) disable iff (reset)
    !access |=> $stable(prdata))
    else $error("read data moved without access");

  // live status and control word reads through the bus path
  do_read_a: assert property (@(posedge clk) disable iff (reset)
    (access && !pwrite && paddr == `STATUS_OFS)
    |=> prdata[`ST_DO_ACTIVE] == $past(do_loop_active))
    else $error("do loop bit wrong on read");
  repeat_read_a: assert property (@(posedge clk) disable iff (reset)
    (access && !pwrite && paddr == `STATUS_OFS)
    |=> prdata[`ST_REPEAT] == $past(repeat_loop_busy))
    else $error("repeat bit wrong on read");
  depth_read_a: assert property (@(posedge clk) disable iff (reset)
    (access && !pwrite && paddr == `CONTROL_OFS)
    |=> prdata[`CC_DEPTH_HI:`CC_DEPTH_LO] == $past(do_nest_depth))
    else $error("nest depth wrong on read");
  either_ovf_read_a: assert property (@(posedge clk) disable iff (reset)
    (access && !pwrite && paddr == `STATUS_OFS)
    |=> prdata[`ST_EITHER_OVF] == $past(s_r.acc_a_overflow || s_r.acc_b_overflow))
    else $error("combined overflow wrong on read");
  prio_read_a: assert property (@(posedge clk) disable iff (reset)
    (access && !pwrite && paddr == `STATUS_OFS)
    |=> prdata[`ST_PRIO_HI:`ST_PRIO_LO] == dsp_cfg.priority_level[2:0])
    else $error("priority low bits differ from config");

  // datapath events
  ovf_copy_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> s_r.acc_a_overflow == $past(acc_events.ovf_a))
    else $error("overflow A not tracked");
  ovf_copy_b_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> s_r.acc_b_overflow == $past(acc_events.ovf_b))
    else $error("overflow B not tracked");
  sticky_noset_b_a: assert property (@(posedge clk) disable iff (reset)
    (!acc_events.sat_b && !s_r.acc_b_sticky_clip) |=> !s_r.acc_b_sticky_clip)
    else $error("sticky clip B set without saturation");
  neg_track_a: assert property (@(posedge clk) disable iff (reset)
    alu_flags.valid
    |=> s_r.neg_flag == $past(alu_flags.byte_op ? alu_flags.result[7] : alu_flags.result[15]))
    else $error("negative flag wrong");
  half_carry_a: assert property (@(posedge clk) disable iff (reset)
    alu_flags.valid |=> s_r.half_carry_flag == $past(alu_flags.carry_low))
    else $error("half carry wrong");
  zero_set_a: assert property (@(posedge clk) disable iff (reset)
    (alu_flags.valid && alu_flags.upd_zero && !alu_flags.byte_op && alu_flags.result == 16'h0000)
    |=> s_r.zero_flag)
    else $error("zero flag not set on zero result");
  zero_clear_a: assert property (@(posedge clk) disable iff (reset)
    (alu_flags.valid && alu_flags.upd_zero && !alu_flags.byte_op && alu_flags.result != 16'h0000)
    |=> !s_r.zero_flag)
    else $error("zero flag kept on non-zero result");

  // priority and control word
  level_seven_a: assert property (@(posedge clk) disable iff (reset)
    (s_r.cpu_priority_level == 3'h7) |-> dsp_cfg.user_irq_block)
    else $error("level seven does not block user interrupts");
  prio_write_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lo && paddr == `STATUS_OFS && !s_r.nesting_disable)
    |=> s_r.cpu_priority_level == $past(pwdata[`ST_PRIO_HI:`ST_PRIO_LO]))
    else $error("priority write lost while unlocked");
  msb_clear_only_a: assert property (@(posedge clk) disable iff (reset)
    !s_r.core_control_reg[`CC_PRIO_MSB] |=> !s_r.core_control_reg[`CC_PRIO_MSB])
    else $error("priority msb set by software");
  unsigned_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (wr_hi && paddr == `CONTROL_OFS) |=> dsp_cfg.unsigned_mul == $past(pwdata[`CC_UNSIGNED]))
    else $error("unsigned control not applied");
  clip_a_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lo && paddr == `CONTROL_OFS) |=> dsp_cfg.clip_a == $past(pwdata[`CC_CLIP_A]))
    else $error("clip A enable not applied");
  clip_b_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lo && paddr == `CONTROL_OFS) |=> dsp_cfg.clip_b == $past(pwdata[`CC_CLIP_B]))
    else $error("clip B enable not applied");
  clip_width_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lo && paddr == `CONTROL_OFS) |=> dsp_cfg.clip_wide == $past(pwdata[`CC_CLIP_WIDTH]))
    else $error("clip width select not applied");
  prog_window_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lo && paddr == `CONTROL_OFS) |=> dsp_cfg.prog_win == $past(pwdata[`CC_PROG_WIN]))
    else $error("program window not applied");

  // early exit request lives only while a loop runs
  early_set_a: assert property (@(posedge clk) disable iff (reset)
    (wr_hi && paddr == `CONTROL_OFS && pwdata[`CC_EARLY_EXIT] && do_loop_active && !do_early_exit_taken)
    |=> dsp_cfg.early_exit)
    else $error("early exit request not raised");
  early_clear_a: assert property (@(posedge clk) disable iff (reset)
    do_early_exit_taken |=> !dsp_cfg.early_exit)
    else $error("early exit request not dropped");

endmodule // cpu_status_core_control

// ==== verif/tb_cpu_status_core_control.sv ====
// self-checking bench for the status/control bank, driven over APB
// assumes the rtl package and map header compile first; bench drives every port itself
`timescale 1ns/10ps
`include "cpu_status_core_control_map.svh"
module tb_cpu_status_core_control;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  cpu_status_core_control_pkg::alu_flags_t alu_flags;
  cpu_status_core_control_pkg::acc_events_t acc_events;
  logic do_loop_active, repeat_loop_busy, do_early_exit_taken;
  logic [2:0] do_nest_depth;
  cpu_status_core_control_pkg::dsp_cfg_t dsp_cfg;
  int error_cnt, cmp_count;

  cpu_status_core_control cpu_status_core_control_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu_flags(alu_flags),
    .acc_events(acc_events), .do_loop_active(do_loop_active), .repeat_loop_busy(repeat_loop_busy),
    .do_nest_depth(do_nest_depth), .do_early_exit_taken(do_early_exit_taken), .dsp_cfg(dsp_cfg));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is seen at a rising edge; answer taken at that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("wrong value pready expected 1 seen stuck low");
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // outputs are combinational from registers: let the edge's updates land first
  task cfg(input logic [11:0] exp);
    @(negedge clk);
    chk("dsp_cfg", {20'h0, dsp_cfg}, {20'h0, exp});
  endtask

  task pulse_acc(input logic [3:0] v);
    @(posedge clk);
    acc_events <= v;
    @(posedge clk);
    acc_events <= 4'h0;
  endtask

  task alu(input logic [21:0] v);
    @(posedge clk);
    alu_flags <= v;
    @(posedge clk);
    alu_flags <= '0;
  endtask

  task t_reset;
    rdc("status", `STATUS_OFS, 32'h0);
    rdc("control", `CONTROL_OFS, 32'h20);
    cfg(12'h100);
    $display("test reset done");
  endtask

  task t_sticky;
    pulse_acc(4'h2);
    rdc("status", `STATUS_OFS, 32'h2400);
    wr(`STATUS_OFS, 32'h2400);
    rdc("status", `STATUS_OFS, 32'h2400);
    pulse_acc(4'h1);
    rdc("status", `STATUS_OFS, 32'h3400);
    wr(`STATUS_OFS, 32'h3000);
    rdc("status", `STATUS_OFS, 32'h0);
    wr(`STATUS_OFS, 32'h3400);
    rdc("status", `STATUS_OFS, 32'h0);
    $display("test sticky done");
  endtask

  task t_ovf;
    @(posedge clk);
    acc_events <= 4'h8;
    rdc("status", `STATUS_OFS, 32'h8800);
    wr(`STATUS_OFS, 32'h0);
    rdc("status", `STATUS_OFS, 32'h8800);
    acc_events <= 4'h4;
    rdc("status", `STATUS_OFS, 32'h4800);
    acc_events <= 4'h0;
    rdc("status", `STATUS_OFS, 32'h0);
    $display("test overflow done");
  endtask

  task t_loops;
    @(posedge clk);
    do_loop_active <= 1'b1;
    repeat_loop_busy <= 1'b1;
    do_nest_depth <= 3'h5;
    rdc("status", `STATUS_OFS, 32'h0210);
    wr(`STATUS_OFS, 32'h0);
    rdc("status", `STATUS_OFS, 32'h0210);
    wr(`CONTROL_OFS, 32'h0720);
    rdc("control", `CONTROL_OFS, 32'h0520);
    do_loop_active <= 1'b0;
    repeat_loop_busy <= 1'b0;
    do_nest_depth <= 3'h7;
    rdc("status", `STATUS_OFS, 32'h0);
    rdc("control", `CONTROL_OFS, 32'h0720);
    do_nest_depth <= 3'h0;
    $display("test loops done");
  endtask

  task t_prio;
    for (int i = 0; i < 8; i++) begin
      wr(`STATUS_OFS, 32'(i << 5));
      rdc("status", `STATUS_OFS, 32'(i << 5));
      cfg(12'h100 | 12'(i << 1) | {11'h0, i == 7});
    end
    wr(`SIDE_OFS, 32'h1);
    wr(`STATUS_OFS, 32'h40);
    rdc("status", `STATUS_OFS, 32'hE0);
    wr(`SIDE_OFS, 32'h0);
    wr(`STATUS_OFS, 32'h0);
    rdc("status", `STATUS_OFS, 32'h0);
    $display("test priority done");
  endtask

  task t_alu;
    alu({1'b1, 1'b0, 16'h8000, 4'hF});
    rdc("status", `STATUS_OFS, 32'h010D);
    alu({1'b1, 1'b0, 16'h0000, 4'h1});
    rdc("status", `STATUS_OFS, 32'h0002);
    alu({1'b1, 1'b0, 16'h0005, 4'h0});
    rdc("status", `STATUS_OFS, 32'h0002);
    alu({1'b1, 1'b1, 16'h0080, 4'h1});
    rdc("status", `STATUS_OFS, 32'h0008);
    wr(`STATUS_OFS, 32'h0);
    $display("test alu done");
  endtask

  task t_ctrl;
    wr(`CONTROL_OFS, 32'h10D4);
    rdc("control", `CONTROL_OFS, 32'h10D4);
    cfg(12'hEC0);
    wr(`CONTROL_OFS, 32'h20);
    cfg(12'h100);
    $display("test control done");
  endtask

  task t_early;
    @(posedge clk);
    do_loop_active <= 1'b1;
    wr(`CONTROL_OFS, 32'h0820);
    cfg(12'h120);
    rdc("control", `CONTROL_OFS, 32'h20);
    @(posedge clk);
    do_early_exit_taken <= 1'b1;
    @(posedge clk);
    do_early_exit_taken <= 1'b0;
    cfg(12'h100);
    wr(`CONTROL_OFS, 32'h20);
    cfg(12'h100);
    do_loop_active <= 1'b0;
    $display("test early exit done");
  endtask

  task t_unmapped;
    apb(1'b1, 12'h00C, 32'hFFFF);
    chk("pslverr", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    chk("prdata", rd, 32'h0);
    rdc("control", `CONTROL_OFS, 32'h20);
    chk("pslverr", {31'h0, err}, 32'h0);
    $display("test unmapped done");
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, do_loop_active, repeat_loop_busy, do_early_exit_taken} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    alu_flags = '0;
    acc_events = '0;
    do_nest_depth = 3'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_sticky();
    t_ovf();
    t_loops();
    t_prio();
    t_alu();
    t_ctrl();
    t_early();
    t_unmapped();
    summarize();
  end
endmodule // tb_cpu_status_core_control
